// >>> hw/gfcs_pkg.sv
package gfcs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 4;
  localparam int unsigned POR_HOLD_NS     = 1000;
  localparam int unsigned POR_HOLD_CYCLES = (POR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DRAIN_LIMIT     = 64;
  localparam int unsigned CNT_W           = 16;

  // ----------------------------------------------------------------
  // Synchroniser lanes
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W     = 7;
  localparam int unsigned LN_S0_TRUE = 0;
  localparam int unsigned LN_S0_COMP = 1;
  localparam int unsigned LN_S1_TRUE = 2;
  localparam int unsigned LN_S1_COMP = 3;
  localparam int unsigned LN_SELECT  = 4;
  localparam int unsigned LN_DIRECT  = 5;
  localparam int unsigned LN_PORNODE = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SYNC_W-1:0] SYNC_RESET = 7'h00;
  localparam logic              SEL_PULLUP = 1'b1;

  // ----------------------------------------------------------------
  // Switch states, Gray coded along the switchover path
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GFCS_RUN       = 2'b00,
    GFCS_DRAIN     = 2'b01,
    GFCS_WAIT_LOW  = 2'b11,
    GFCS_WAIT_HIGH = 2'b10
  } gfcs_state_t;

endpackage

// >>> hw/gfcs_switch.sv
`timescale 1ns/1ns
module gfcs_switch #(
  parameter int unsigned POR_HOLD    = gfcs_pkg::POR_HOLD_CYCLES,
  parameter int unsigned DRAIN_CYCLES = gfcs_pkg::DRAIN_LIMIT
) (
  input  wire logic clk,                  // 250 MHz sampling clock
  input  wire logic resetn,               // Async reset, active low
  input  wire logic clock_source_zero,    // Source zero, true
  input  wire logic clock_source_zero_n,  // Source zero, complement
  input  wire logic clock_source_one,     // Source one, true
  input  wire logic clock_source_one_n,   // Source one, complement
  input  wire logic select_in,            // Select level
  input  wire logic select_driven,        // Select pin is driven
  input  wire logic por_timing_node,      // High once timing cap charged
  input  wire logic por_node_direct,      // Timing node tied to supply
  output logic      clock_out,            // Output clock, true
  output logic      clock_out_n,          // Output clock, complement
  output logic      runt_suppression      // Suppression active
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (POR_HOLD < 1 || POR_HOLD > 65535) begin : g_chk_por
    $error("POR_HOLD out of range");
  end
  if (DRAIN_CYCLES < 1 || DRAIN_CYCLES > 65535) begin : g_chk_drain
    $error("DRAIN_CYCLES out of range");
  end

  localparam logic [gfcs_pkg::CNT_W-1:0] POR_LAST   = POR_HOLD[gfcs_pkg::CNT_W-1:0];
  localparam logic [gfcs_pkg::CNT_W-1:0] DRAIN_LAST = DRAIN_CYCLES[gfcs_pkg::CNT_W-1:0];

  // Fail-safe: a pair with equal legs carries no valid swing
  function automatic logic pair_valid(input logic t, input logic c);
    pair_valid = t ^ c;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [gfcs_pkg::SYNC_W-1:0] sync1_q;
  logic [gfcs_pkg::SYNC_W-1:0] sync2_q;
  logic                        sel_raw;

  assign sel_raw = select_driven ? select_in : gfcs_pkg::SEL_PULLUP;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= gfcs_pkg::SYNC_RESET;
      sync2_q <= gfcs_pkg::SYNC_RESET;
    end else begin
      sync1_q <= {por_timing_node, por_node_direct, sel_raw, clock_source_one_n,
                  clock_source_one, clock_source_zero_n, clock_source_zero};
      sync2_q <= sync1_q;
    end
  end

  logic sel_s;
  assign sel_s = sync2_q[gfcs_pkg::LN_SELECT];

  // ----------------------------------------------------------------
  // Fail-safe source levels
  // ----------------------------------------------------------------
  logic [1:0] lvl_q;
  logic [1:0] lvl_prev_q;

  // Dead pair keeps its last level, so nothing downstream can chatter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lvl_q <= 2'h0;
    end else begin
      if (pair_valid(sync2_q[gfcs_pkg::LN_S0_TRUE], sync2_q[gfcs_pkg::LN_S0_COMP])) begin
        lvl_q[0] <= sync2_q[gfcs_pkg::LN_S0_TRUE];
      end
      if (pair_valid(sync2_q[gfcs_pkg::LN_S1_TRUE], sync2_q[gfcs_pkg::LN_S1_COMP])) begin
        lvl_q[1] <= sync2_q[gfcs_pkg::LN_S1_TRUE];
      end
    end
  end

  // Previous levels let the switch wait for a real falling edge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lvl_prev_q <= 2'h0;
    end else begin
      lvl_prev_q <= lvl_q;
    end
  end

  // ----------------------------------------------------------------
  // Power-on hold and bypass strap
  // ----------------------------------------------------------------
  logic                       por_done_q;
  logic [gfcs_pkg::CNT_W-1:0] por_cnt_q;
  logic                       bypass_q;

  // Strap is caught after release, never loaded by the reset itself
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bypass_q <= 1'b0;
    end else begin
      bypass_q <= sync2_q[gfcs_pkg::LN_DIRECT];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      por_cnt_q  <= 16'h0000;
      por_done_q <= 1'b0;
    end else if (!por_done_q && sync2_q[gfcs_pkg::LN_PORNODE]) begin
      if (por_cnt_q == POR_LAST - 16'h0001) begin
        por_done_q <= 1'b1;
      end
      por_cnt_q <= por_cnt_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Switchover state machine
  // ----------------------------------------------------------------
  gfcs_pkg::gfcs_state_t      st_q;
  logic                       cur_q;
  logic [gfcs_pkg::CNT_W-1:0] drain_cnt_q;
  logic                       drain_timeout;

  // A source stuck high would freeze the drain; the timeout gives it up
  assign drain_timeout = (drain_cnt_q == DRAIN_LAST - 16'h0001);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q        <= gfcs_pkg::GFCS_RUN;
      cur_q       <= 1'b1;
      drain_cnt_q <= 16'h0000;
    end else if (!por_done_q || bypass_q) begin
      st_q        <= gfcs_pkg::GFCS_RUN;
      cur_q       <= sel_s;
      drain_cnt_q <= 16'h0000;
    end else begin
      case (st_q)
        gfcs_pkg::GFCS_RUN: begin
          drain_cnt_q <= 16'h0000;
          if (sel_s != cur_q) begin
            st_q <= gfcs_pkg::GFCS_DRAIN;
          end
        end
        gfcs_pkg::GFCS_DRAIN: begin
          drain_cnt_q <= drain_cnt_q + 16'h0001;
          if (!lvl_q[cur_q] || drain_timeout) begin
            st_q  <= gfcs_pkg::GFCS_WAIT_LOW;
            cur_q <= sel_s;
          end
        end
        gfcs_pkg::GFCS_WAIT_LOW: begin
          cur_q <= sel_s;
          // A level alone would let a runt low through; wait for a fresh fall
          if (!lvl_q[cur_q] && lvl_prev_q[cur_q] && sel_s == cur_q) begin
            st_q <= gfcs_pkg::GFCS_WAIT_HIGH;
          end
        end
        gfcs_pkg::GFCS_WAIT_HIGH: begin
          // A dead new source keeps the output low until it recovers
          if (sel_s != cur_q) begin
            cur_q <= sel_s;
            st_q  <= gfcs_pkg::GFCS_WAIT_LOW;
          end else if (lvl_q[cur_q]) begin
            st_q <= gfcs_pkg::GFCS_RUN;
          end
        end
        default: begin
          st_q <= gfcs_pkg::GFCS_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------
  logic out_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_q <= 1'b0;
    end else if (bypass_q) begin
      out_q <= lvl_q[sel_s];
    end else if (!por_done_q) begin
      out_q <= 1'b0;
    end else begin
      case (st_q)
        gfcs_pkg::GFCS_RUN: begin
          if (sel_s != cur_q) begin
            out_q <= out_q & lvl_q[cur_q];
          end else begin
            out_q <= lvl_q[cur_q];
          end
        end
        gfcs_pkg::GFCS_DRAIN: begin
          out_q <= out_q & lvl_q[cur_q] & ~drain_timeout;
        end
        gfcs_pkg::GFCS_WAIT_LOW: begin
          out_q <= 1'b0;
        end
        gfcs_pkg::GFCS_WAIT_HIGH: begin
          out_q <= lvl_q[cur_q] & (sel_s == cur_q);
        end
        default: begin
          out_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  // Complement is a plain inverter, so the pair can never agree
  assign clock_out        = out_q;
  assign clock_out_n      = ~out_q;
  assign runt_suppression = ~bypass_q;

endmodule

// >>> tb/gfcs_sources.sv
`timescale 1ns/1ns
module gfcs_sources (
  input  wire logic run0,                 // Zero runs
  input  wire logic run1,                 // One runs
  output logic      clock_source_zero,    // Zero, true
  output logic      clock_source_zero_n,  // Zero, comp
  output logic      clock_source_one,     // One, true
  output logic      clock_source_one_n    // One, comp
);
  logic ph0 = 1'b0;
  logic ph1 = 1'b0;
  always #20 ph0 = !ph0;
  always #28 ph1 = !ph1;
  // Stopped source drops to zero differential, not a held level
  assign clock_source_zero   = run0 && ph0;
  assign clock_source_zero_n = run0 && !ph0;
  assign clock_source_one    = run1 && ph1;
  assign clock_source_one_n  = run1 && !ph1;
endmodule

// >>> tb/gfcs_switch_assertions.sv
`timescale 1ns/1ns
module gfcs_switch_assertions #(parameter int unsigned POR_HOLD = 4) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clock_source_zero,
  input wire logic clock_source_zero_n,
  input wire logic clock_source_one,
  input wire logic clock_source_one_n,
  input wire logic select_in,
  input wire logic select_driven,
  input wire logic por_timing_node,
  input wire logic por_node_direct,
  input wire logic clock_out,
  input wire logic clock_out_n,
  input wire logic runt_suppression
);
  logic [15:0] hi_q;
  logic        pick, lvl, ok, dead, late;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  assign pick = !select_driven || select_in;
  assign lvl  = pick ? clock_source_one : clock_source_zero;
  assign ok   = pick ? clock_source_one != clock_source_one_n
                     : clock_source_zero != clock_source_zero_n;
  assign dead = !ok;
  // Skip the power-up release, where a first partial phase may pass
  assign late = runt_suppression && hi_q > POR_HOLD + 8;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hi_q <= 16'h0000;
    else if (!por_timing_node) hi_q <= 16'h0000;
    else if (hi_q != 16'hffff) hi_q <= hi_q + 16'h0001;
  end
  sequence steady_pick;
    (!runt_suppression && $stable(pick)) [*5];
  endsequence
  sequence dead_pick;
    (dead && !runt_suppression && $stable(pick)) [*6];
  endsequence
  inverse_out_a: assert property (clock_out_n == !clock_out)
    else $error("complement wrong");
  strap_bypass_a: assert property ($past(resetn, 3) |->
    runt_suppression == !$past(por_node_direct, 3)) else $error("strap wrong");
  por_hold_a: assert property (runt_suppression && hi_q < POR_HOLD |-> !clock_out)
    else $error("output during hold");
  high_phase_a: assert property (late && $rose(clock_out) |-> clock_out [*3])
    else $error("short high");
  low_phase_a: assert property (late && $fell(clock_out) |-> !clock_out [*3])
    else $error("short low");
  dead_hold_a: assert property (dead_pick |-> $stable(clock_out))
    else $error("dead source moved output");
  mux_follow_a: assert property (steady_pick |->
    !$past(ok, 4) || clock_out == $past(lvl, 4)) else $error("wrong source");
endmodule

// >>> tb/gfcs_switch_tb.sv
`timescale 1ns/1ns
module gfcs_switch_tb;
  logic clk, resetn, run0, run1, select_in, select_driven, por_timing_node, por_node_direct;
  logic clock_source_zero, clock_source_zero_n, clock_source_one, clock_source_one_n;
  logic clock_out, clock_out_n, runt_suppression, prev_q;
  int   mismatches, compares, cyc, rises, run_len, min_run;
  gfcs_sources gfcs_sources_i (.*);
  gfcs_switch #(.POR_HOLD(4), .DRAIN_CYCLES(8)) gfcs_switch_i (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Output is looked at mid-cycle, where it has settled
  always @(negedge clk) begin
    cyc++;
    if (clock_out !== prev_q) begin
      rises += int'(clock_out === 1'b1);
      if (run_len < min_run) min_run = run_len;
      run_len = 0;
    end
    run_len++;
    prev_q = clock_out;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  task check(input logic seen, input logic want);
    compares++;
    if (seen !== want) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %b want %b", $time, seen, want);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // First partial phase of a window is never scored
  task win(input int n);
    rises = 0;
    run_len = 1000;
    min_run = 1000;
    tick(n);
  endtask
  task boot(input logic direct, input logic node);
    resetn = 1'b0;
    por_node_direct = direct;
    por_timing_node = node;
    tick(10);
    resetn = 1'b1;
    tick(20);
  endtask
  task test_bypass;
    boot(1'b1, 1'b1);
    check(runt_suppression, 1'b0);
    for (int i = 0; i < 3; i++) begin
      select_driven = i != 2;
      select_in = i == 1;
      tick(10);
      win(140);
      check((rises - (i > 0 ? 10 : 14)) inside {[-1:1]}, 1'b1);
    end
    select_driven = 1'b1;
    run0 = 1'b0;
    run1 = 1'b0;
    tick(10);
    win(60);
    check(min_run == 1000, 1'b1);
    run0 = 1'b1;
    run1 = 1'b1;
    $display("bypass done");
  endtask
  task test_por;
    boot(1'b0, 1'b0);
    select_in = 1'b1;
    check(runt_suppression, 1'b1);
    win(60);
    check(rises == 0, 1'b1);
    por_timing_node = 1'b1;
    win(5);
    check(rises == 0, 1'b1);
    tick(10);
    win(140);
    check(rises inside {[9:11]}, 1'b1);
    $display("power-up done");
  endtask
  task test_switch;
    boot(1'b0, 1'b1);
    select_in = 1'b0;
    tick(10);
    win(140);
    check(rises inside {[13:15]}, 1'b1);
    for (int i = 0; i < 6; i++) begin
      select_in = !select_in;
      tick(i == 2 ? 3 : 23);
    end
    tick(30);
    check(min_run >= 5, 1'b1);
    run0 = 1'b0;
    tick(10);
    win(60);
    check(min_run == 1000, 1'b1);
    select_in = 1'b1;
    tick(40);
    win(140);
    check(rises inside {[9:11]} && min_run >= 5, 1'b1);
    run0 = 1'b1;
    $display("switch done");
  endtask
  initial begin
    resetn = 1'b0;
    run0 = 1'b1;
    run1 = 1'b1;
    select_in = 1'b1;
    select_driven = 1'b1;
    por_timing_node = 1'b1;
    por_node_direct = 1'b0;
    test_bypass();
    test_por();
    test_switch();
    finish_test();
  end
  task finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
endmodule
bind gfcs_switch gfcs_switch_assertions #(.POR_HOLD(POR_HOLD)) gfcs_switch_assertions_i (.*);
